/* File: rsw_bc_model.sv */
`timescale 1ns/1ps
`default_nettype none
module rsw_bc_model (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic go,
  input wire logic chan_b,
  input wire logic rep,
  input wire logic [3:0] gap,
  output logic valid_cmd_a,
  output logic valid_cmd_b,
  output logic repeat_status_code,
  output logic status_tx_start,
  output logic status_tx_done,
  output logic mbusy
);
  logic [4:0] cnt;
  // one command, then the status reply; gap stretches the reply to model a slow bus
  always @(posedge clk_sys)
  begin
    valid_cmd_a <= 1'h0;
    valid_cmd_b <= 1'h0;
    status_tx_start <= 1'h0;
    status_tx_done <= 1'h0;
    if (rst)
    begin
      mbusy <= 1'h0;
      cnt <= 5'h00;
      repeat_status_code <= 1'h0;
    end
    else if (go && !mbusy)
    begin
      mbusy <= 1'h1;
      cnt <= 5'h00;
      valid_cmd_a <= !chan_b;
      valid_cmd_b <= chan_b;
      repeat_status_code <= rep;
    end
    else if (mbusy)
    begin
      cnt <= cnt + 5'h01;
      if (cnt == 5'h02)
        status_tx_start <= 1'h1;
      if (cnt == 5'h03 + {1'h0, gap})
        status_tx_done <= 1'h1;
      if (cnt == 5'h04 + {1'h0, gap})
      begin
        mbusy <= 1'h0;
        repeat_status_code <= 1'h0;
      end
    end
  end
endmodule
`default_nettype wire

/* File: rsw_defs.vh */
`ifndef RSW_DEFS_VH
`define RSW_DEFS_VH

// register indices on the plain register port
`define RSW_ADDR_W 4
`define RSW_IDX_STATUS 4'h0
`define RSW_IDX_MODE 4'h1
`define RSW_IDX_TSC 4'hA
`define RSW_IDX_CFG 4'hE
`define RSW_IDX_PSR 4'hF

// reset values
`define RSW_CFG_RST 16'h0000
`define RSW_PSR_RST 16'h0000
`define RSW_TSC_RST 16'h0000

// operational configuration fields
`define RSW_CFG_SRC 4
`define RSW_CFG_ACT_DIS_A 10
`define RSW_CFG_ACT_DIS_B 11
`define RSW_CFG_STOP_EN 12

// programmable status fields
`define RSW_PSR_TF 0
`define RSW_PSR_SSF 2
`define RSW_PSR_BUSY 3
`define RSW_PSR_BCR 4
`define RSW_PSR_RSV_LO 5
`define RSW_PSR_RSV_HI 7
`define RSW_PSR_SRQ 8
`define RSW_PSR_INSTR 9
`define RSW_PSR_ME 10
`define RSW_PSR_FORCED_BUSY_IN_N 11
`define RSW_PSR_SRQ_NBUSY 12
`define RSW_PSR_TF_SEL13 13
`define RSW_PSR_TF_SEL14 14
`define RSW_PSR_IMM_CLR 15
// bits wiped after each status word in immediate-clear operation
`define RSW_PSR_CLR_MASK 16'h07FD

// terminal status control fields
`define RSW_TSC_FORCED_BUSY_IN_N 9
`define RSW_TSC_SRQ 10
`define RSW_TSC_TF 11
`define RSW_TSC_DBCA_EN 12
`define RSW_TSC_SSF 13
`define RSW_TSC_BUSY 14
`define RSW_TSC_INSTR 15
`define RSW_TSC_CLR_MASK 16'hEC00

// status word bit positions
`define RSW_SW_TA_HI 15
`define RSW_SW_TA_LO 11
`define RSW_SW_ME 10
`define RSW_SW_INSTR 9
`define RSW_SW_SRQ 8
`define RSW_SW_RSV_HI 7
`define RSW_SW_RSV_LO 5
`define RSW_SW_BCR 4
`define RSW_SW_BUSY 3
`define RSW_SW_SSF 2
`define RSW_SW_DBCA 1
`define RSW_SW_TF 0

// transmitter fail-safe timing
`define RSW_CLK_HZ 40000000
`define RSW_TXINH_US 660
`define RSW_TXINH_CYC ((`RSW_TXINH_US * (`RSW_CLK_HZ / 1000000)))

`endif

/* File: rsw_status_ctrl.v */
`timescale 1ns/1ps
`default_nettype none
`include "rsw_defs.vh"

// Overview of operation
// - bc stop-enable interrupt halts processing until interrupt reset
// - rt stop-enable interrupt forces busy until cleared
// - forced busy from pin low or register bits
// - forced busy masks interrupts, dma; acknowledge asserted
// - valid command on enabled channel asserts activity
// - config bits disable per-channel activity monitoring
// - per-channel transmit timer, 660 us fail-safe
// - immediate clear wipes programmable bits after status
// - status or last-command mode code repeats previous only with immediate clear set
// - address field from pins or address bits
// - message error from errors, or programmable bit
// - instrumentation bit selected by status source
// - service request bit selected by status source
// - service request may mirror inverted busy
// - reserved bits always from programmable bits 5-7
// - broadcast received bit by source option
// - busy from control, forced busy, programmable bit
// - subsystem flag sources selected by status source
// - dynamic bus control acceptance on legal code
// - terminal flag base sources by status source
// - terminal flag from busy, subsystem, any bit
// - inhibit mode code keeps terminal flag clear
// - status source from pin or config bit
module rsw_status_ctrl #(
  parameter TXINH_CYC = `RSW_TXINH_CYC,
  parameter TA_REG_DEFAULT = 1'b0
) (
  input wire clk_sys,
  input wire rst,
  input wire [`RSW_ADDR_W-1:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [15:0] reg_rdata,
  input wire mode_bc,
  input wire forced_busy_in_n,
  input wire status_source_select,
  input wire [4:0] terminal_address_pins,
  input wire ta_from_register,
  input wire [4:0] ta_register_bits,
  input wire subsystem_fail_in,
  input wire std_irq_event,
  input wire hp_irq_event,
  input wire irq_reset_write,
  input wire valid_cmd_a,
  input wire valid_cmd_b,
  input wire msg_error_event,
  input wire illegal_cmd,
  input wire broadcast_cmd,
  input wire broadcast_enable,
  input wire dbc_legal_cmd,
  input wire bit_failure,
  input wire inhibit_tf_code,
  input wire override_tf_code,
  input wire repeat_status_code,
  input wire status_tx_start,
  input wire status_tx_done,
  input wire tx_start_a,
  input wire tx_done_a,
  input wire tx_start_b,
  input wire tx_done_b,
  output reg [15:0] status_word,
  output reg busy_acknowledge_out,
  output reg irq_disable,
  output reg dma_inhibit,
  output reg bc_halt,
  output reg active_out,
  output reg tx_inhibit_timer_chan_a,
  output reg tx_inhibit_timer_chan_b
);

  // writable registers
  reg [15:0] operational_config;
  reg [15:0] programmable_status;
  reg [15:0] terminal_status_control;

  // latched events
  reg stop_busy;
  reg msg_err_latch;
  reg bcast_latch;
  reg dbca_latch;
  reg tf_inhibit;
  reg [15:0] last_status;

  // synchronised pins and timer outputs
  wire forced_busy_in_n_n_s;
  wire src_pin_s;
  wire ssf_s;
  wire [4:0] ta_pins_s;
  wire [1:0] timer_on;

  // combinational status assembly
  reg src_std;
  reg forced_busy;
  reg act_dis_a;
  reg act_dis_b;
  reg [4:0] ta_field;
  reg msg_err_status_bit;
  reg instr_bit;
  reg busy_bit;
  reg ssf_bit;
  reg srq_bit;
  reg bcr_bit;
  reg dbca_bit;
  reg [2:0] rsv_bits;
  reg tf_base;
  reg tf_bit;
  reg [15:0] next_status;
  reg irq_any;

  // address decode shared by the write and read paths
  function hit;
    input [`RSW_ADDR_W-1:0] a;
    input [`RSW_ADDR_W-1:0] idx;
    begin
      hit = (a == idx);
    end
  endfunction

  // asynchronous pins pass two flops before use
  rsw_sync2 #(
    .WIDTH(8),
    .INIT(8'h81)
  ) u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .din({forced_busy_in_n, terminal_address_pins, subsystem_fail_in, status_source_select}),
    .dout({forced_busy_in_n_n_s, ta_pins_s, ssf_s, src_pin_s})
  );

  // per-channel transmitter fail-safe timers
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1)
    begin : g_txinh
      rsw_txinh_timer #(
        .CNT_W(16),
        .LIMIT(TXINH_CYC[15:0])
      ) u_timer (
        .clk_sys(clk_sys),
        .rst(rst),
        .tx_start(ch == 0 ? tx_start_a : tx_start_b),
        .tx_done(ch == 0 ? tx_done_a : tx_done_b),
        .timer_on(timer_on[ch])
      );
    end
  endgenerate

  // mode and source selection
  always @*
  begin
    src_std = operational_config[`RSW_CFG_SRC] | src_pin_s;
    act_dis_a = operational_config[`RSW_CFG_ACT_DIS_A];
    act_dis_b = operational_config[`RSW_CFG_ACT_DIS_B];
    // forced busy exists only in terminal mode
    forced_busy = ~mode_bc & (~forced_busy_in_n_n_s | programmable_status[`RSW_PSR_FORCED_BUSY_IN_N] |
      terminal_status_control[`RSW_TSC_FORCED_BUSY_IN_N] | stop_busy);
    irq_any = std_irq_event | hp_irq_event;
  end

  // bit-by-bit status word assembly
  always @*
  begin
    ta_field = ta_from_register ? ta_register_bits : ta_pins_s;
    msg_err_status_bit = msg_err_latch |
      (~src_std & programmable_status[`RSW_PSR_ME]);
    instr_bit = src_std ? terminal_status_control[`RSW_TSC_INSTR] :
      programmable_status[`RSW_PSR_INSTR];
    // a forced busy can be kept off the wire with both select bits set
    busy_bit = terminal_status_control[`RSW_TSC_BUSY] |
      (~src_std & programmable_status[`RSW_PSR_BUSY]) |
      (forced_busy & ~(programmable_status[`RSW_PSR_TF_SEL13] &
      programmable_status[`RSW_PSR_TF_SEL14]));
    ssf_bit = src_std ? (terminal_status_control[`RSW_TSC_SSF] | ssf_s | bit_failure) :
      programmable_status[`RSW_PSR_SSF];
    if (programmable_status[`RSW_PSR_SRQ_NBUSY])
      srq_bit = ~busy_bit;
    else
      srq_bit = src_std ? terminal_status_control[`RSW_TSC_SRQ] :
        programmable_status[`RSW_PSR_SRQ];
    rsv_bits = programmable_status[`RSW_PSR_RSV_HI:`RSW_PSR_RSV_LO];
    bcr_bit = src_std ? bcast_latch : programmable_status[`RSW_PSR_BCR];
    dbca_bit = src_std & dbca_latch;
    tf_base = src_std ? (terminal_status_control[`RSW_TSC_TF] | bit_failure) :
      programmable_status[`RSW_PSR_TF];
    tf_bit = tf_base |
      (programmable_status[`RSW_PSR_TF_SEL13] & ~programmable_status[`RSW_PSR_TF_SEL14] &
      (busy_bit | ssf_bit)) |
      (~programmable_status[`RSW_PSR_TF_SEL13] & programmable_status[`RSW_PSR_TF_SEL14] &
      (msg_err_status_bit | instr_bit | srq_bit | (|rsv_bits) | bcr_bit |
      busy_bit | ssf_bit | dbca_bit));
    tf_bit = tf_bit & ~tf_inhibit;
    next_status = 16'h0000;
    next_status[`RSW_SW_TA_HI:`RSW_SW_TA_LO] = ta_field;
    next_status[`RSW_SW_ME] = msg_err_status_bit;
    next_status[`RSW_SW_INSTR] = instr_bit;
    next_status[`RSW_SW_SRQ] = srq_bit;
    next_status[`RSW_SW_RSV_HI:`RSW_SW_RSV_LO] = rsv_bits;
    next_status[`RSW_SW_BCR] = bcr_bit;
    next_status[`RSW_SW_BUSY] = busy_bit;
    next_status[`RSW_SW_SSF] = ssf_bit;
    next_status[`RSW_SW_DBCA] = dbca_bit;
    next_status[`RSW_SW_TF] = tf_bit;
  end

  // register writes; a host write in the clear cycle beats the auto clear
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      operational_config <= `RSW_CFG_RST;
      programmable_status <= `RSW_PSR_RST;
      terminal_status_control <= `RSW_TSC_RST;
    end
    else
    begin
      if (status_tx_done && programmable_status[`RSW_PSR_IMM_CLR] && !mode_bc)
      begin
        programmable_status <= programmable_status & ~`RSW_PSR_CLR_MASK;
        terminal_status_control <= terminal_status_control & ~`RSW_TSC_CLR_MASK;
      end
      if (reg_wr && hit(reg_addr, `RSW_IDX_CFG))
        operational_config <= reg_wdata;
      if (reg_wr && hit(reg_addr, `RSW_IDX_PSR))
        programmable_status <= reg_wdata;
      if (reg_wr && hit(reg_addr, `RSW_IDX_TSC))
        terminal_status_control <= reg_wdata;
    end
  end

  // stop-enable latches; a new interrupt wins over its clear
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      stop_busy <= 1'b0;
      bc_halt <= 1'b0;
    end
    else
    begin
      if (irq_any && operational_config[`RSW_CFG_STOP_EN] && !mode_bc &&
        (!forced_busy || stop_busy))
        stop_busy <= 1'b1;
      else if (irq_reset_write || mode_bc)
        stop_busy <= 1'b0;
      if (irq_any && operational_config[`RSW_CFG_STOP_EN] && mode_bc)
        bc_halt <= 1'b1;
      else if (irq_reset_write || !mode_bc)
        bc_halt <= 1'b0;
    end
  end

  // message events held until the status word carrying them is sent
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      msg_err_latch <= 1'b0;
      bcast_latch <= 1'b0;
      dbca_latch <= 1'b0;
    end
    else
    begin
      if (msg_error_event || illegal_cmd)
        msg_err_latch <= 1'b1;
      else if (status_tx_done && !repeat_status_code)
        msg_err_latch <= 1'b0;
      if (broadcast_cmd && broadcast_enable)
        bcast_latch <= 1'b1;
      else if (status_tx_done && !repeat_status_code)
        bcast_latch <= 1'b0;
      if (dbc_legal_cmd && !broadcast_cmd && terminal_status_control[`RSW_TSC_DBCA_EN])
        dbca_latch <= 1'b1;
      else if (status_tx_done && !repeat_status_code)
        dbca_latch <= 1'b0;
    end
  end

  // terminal flag inhibit holds until the override code or a reset
  always @(posedge clk_sys)
  begin
    if (rst)
      tf_inhibit <= 1'b0;
    else if (inhibit_tf_code)
      tf_inhibit <= 1'b1;
    else if (override_tf_code)
      tf_inhibit <= 1'b0;
  end

  // word is frozen at transmission start so earlier writes count
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      status_word <= 16'h0000;
      last_status <= 16'h0000;
    end
    else if (status_tx_start && !mode_bc)
    begin
      if (repeat_status_code && programmable_status[`RSW_PSR_IMM_CLR])
        status_word <= last_status;
      else
      begin
        status_word <= next_status;
        last_status <= next_status;
      end
    end
  end

  // forced busy effects and pin-facing outputs, all registered
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      busy_acknowledge_out <= 1'b0;
      irq_disable <= 1'b0;
      dma_inhibit <= 1'b0;
      active_out <= 1'b0;
      tx_inhibit_timer_chan_a <= 1'b0;
      tx_inhibit_timer_chan_b <= 1'b0;
    end
    else
    begin
      busy_acknowledge_out <= forced_busy;
      irq_disable <= forced_busy;
      dma_inhibit <= forced_busy;
      // one-cycle pulse per valid command on an enabled channel
      active_out <= (valid_cmd_a & ~act_dis_a) | (valid_cmd_b & ~act_dis_b);
      tx_inhibit_timer_chan_a <= timer_on[0];
      tx_inhibit_timer_chan_b <= timer_on[1];
    end
  end

  // read data one cycle after the strobe, zero otherwise
  always @(posedge clk_sys)
  begin
    if (rst)
      reg_rdata <= 16'h0000;
    else if (reg_rd)
    begin
      if (hit(reg_addr, `RSW_IDX_CFG))
        reg_rdata <= operational_config;
      else if (hit(reg_addr, `RSW_IDX_PSR))
        reg_rdata <= programmable_status;
      else if (hit(reg_addr, `RSW_IDX_TSC))
        reg_rdata <= terminal_status_control;
      else if (hit(reg_addr, `RSW_IDX_STATUS))
        reg_rdata <= next_status;
      else if (hit(reg_addr, `RSW_IDX_MODE))
        reg_rdata <= {9'h000, tf_inhibit, src_std, bc_halt, stop_busy,
          forced_busy, timer_on};
      else
        reg_rdata <= 16'h0000;
    end
    else
      reg_rdata <= 16'h0000;
  end

endmodule
`default_nettype wire

/* File: rsw_status_ctrl_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
`include "rsw_defs.vh"
module rsw_status_ctrl_asserts (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [`RSW_ADDR_W-1:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic mode_bc,
  input wire logic irq_reset_write,
  input wire logic valid_cmd_a,
  input wire logic ta_from_register,
  input wire logic [4:0] ta_register_bits,
  input wire logic repeat_status_code,
  input wire logic status_tx_start,
  input wire logic status_tx_done,
  input wire logic tx_start_a,
  input wire logic [15:0] status_word,
  input wire logic busy_acknowledge_out,
  input wire logic irq_disable,
  input wire logic dma_inhibit,
  input wire logic bc_halt,
  input wire logic active_out,
  input wire logic tx_inhibit_timer_chan_a
);
  logic [15:0] cfg_sh;
  logic [15:0] psr_sh;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  // copies of host settings; the auto-clear must be mirrored or field checks drift
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      cfg_sh <= 16'h0000;
      psr_sh <= 16'h0000;
    end
    else
    begin
      if (reg_wr && reg_addr == `RSW_IDX_CFG)
        cfg_sh <= reg_wdata;
      if (reg_wr && reg_addr == `RSW_IDX_PSR)
        psr_sh <= reg_wdata;
      else if (status_tx_done && psr_sh[15] && !mode_bc)
        psr_sh <= psr_sh & ~`RSW_PSR_CLR_MASK;
    end
  end
  chk_busy_ack:
    assert property (busy_acknowledge_out == irq_disable && busy_acknowledge_out == dma_inhibit)
    else $error("busy outputs differ");
  chk_busy_word:
    assert property (status_tx_start && !mode_bc && !repeat_status_code &&
      !(psr_sh[13] && psr_sh[14]) ##1 busy_acknowledge_out |-> status_word[3])
    else $error("busy bit missing in forced busy");
  chk_act_off:
    assert property (cfg_sh[11:10] == 2'h3 && $past(cfg_sh[11:10]) == 2'h3 |-> !active_out)
    else $error("activity while both disabled");
  chk_act_pulse:
    assert property (!mode_bc && valid_cmd_a && !cfg_sh[10] |=> active_out)
    else $error("activity missing");
  chk_timer_on:
    assert property (tx_start_a |-> ##2 tx_inhibit_timer_chan_a)
    else $error("timer a not on");
  chk_ta_field:
    assert property (status_tx_start && ta_from_register && !repeat_status_code
      |=> status_word[15:11] == $past(ta_register_bits))
    else $error("address field wrong");
  chk_rsv_field:
    assert property (status_tx_start && !repeat_status_code
      |=> status_word[7:5] == $past(psr_sh[7:5]))
    else $error("reserved field wrong");
  chk_srq_nbusy:
    assert property (status_tx_start && !repeat_status_code && psr_sh[12]
      |=> status_word[8] != status_word[3])
    else $error("service request not inverse busy");
  chk_bc_hold:
    assert property (bc_halt && !irq_reset_write && !$past(irq_reset_write) |=> bc_halt)
    else $error("halt dropped early");
  cover property (status_tx_start && repeat_status_code);
  cover property (busy_acknowledge_out && status_tx_start);
  cover property ($fell(bc_halt));
endmodule
`default_nettype wire

/* File: rsw_sync2.v */
`timescale 1ns/1ps
`default_nettype none

module rsw_sync2 #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
  input wire clk_sys,
  input wire rst,
  input wire [WIDTH-1:0] din,
  output reg [WIDTH-1:0] dout
);

  reg [WIDTH-1:0] meta;

  // first stage feeds only the second stage
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      meta <= INIT;
      dout <= INIT;
    end
    else
    begin
      meta <= din;
      dout <= meta;
    end
  end

endmodule
`default_nettype wire

/* File: rsw_txinh_timer.v */
`timescale 1ns/1ps
`default_nettype none

module rsw_txinh_timer #(
  parameter CNT_W = 16,
  parameter [CNT_W-1:0] LIMIT = 16'd26400
) (
  input wire clk_sys,
  input wire rst,
  input wire tx_start,
  input wire tx_done,
  output reg timer_on
);

  reg [CNT_W-1:0] count;

  // on at start, off at completion or fail-safe expiry
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      timer_on <= 1'b0;
      count <= {CNT_W{1'b0}};
    end
    else if (tx_start)
    begin
      timer_on <= 1'b1;
      count <= {CNT_W{1'b0}};
    end
    else if (timer_on)
    begin
      if (tx_done || (count == LIMIT - 1'b1))
        timer_on <= 1'b0; // stuck transmitter is cut off
      count <= count + 1'b1;
    end
  end

endmodule
`default_nettype wire

/* File: rt_status_word_and_busy_control_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "rsw_defs.vh"
module rt_status_word_and_busy_control_bench;
  logic clk_sys = 1'h0;
  logic rst = 1'h1;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'h0, reg_rd = 1'h0, mode_bc = 1'h0, forced_busy_in_n = 1'h1;
  logic status_source_select = 1'h0, ta_from_register = 1'h0, subsystem_fail_in = 1'h0;
  logic bit_failure = 1'h0, illegal_cmd = 1'h0, broadcast_enable = 1'h1, tx_done_a = 1'h0;
  logic [4:0] terminal_address_pins = 5'h15, ta_register_bits = 5'h0A;
  logic [10:0] pl = 11'h000;
  logic go = 1'h0, chan_b = 1'h0, rep = 1'h0;
  logic [15:0] n_act = 16'h0000;
  int n_errors = 0;
  int comparisons = 0;
  wire logic std_irq_event, hp_irq_event, irq_reset_write, msg_error_event, broadcast_cmd;
  wire logic dbc_legal_cmd, inhibit_tf_code, override_tf_code, tx_start_a, tx_start_b;
  wire logic tx_done_b, valid_cmd_a, valid_cmd_b, repeat_status_code, mbusy;
  wire logic status_tx_start, status_tx_done, busy_acknowledge_out, irq_disable;
  wire logic dma_inhibit, bc_halt, active_out, tx_inhibit_timer_chan_a, tx_inhibit_timer_chan_b;
  wire logic [15:0] reg_rdata, status_word;
  wire logic [3:0] gap;
  wire logic [2:0] ws;
  // single-cycle event inputs share one vector so one task can pulse any mix
  assign {tx_done_b, tx_start_b, tx_start_a, override_tf_code, inhibit_tf_code, dbc_legal_cmd,
    broadcast_cmd, msg_error_event, irq_reset_write, hp_irq_event, std_irq_event} = pl;
  assign gap = {1'h0, rep, 2'h0};
  assign ws = {mbusy, bc_halt, busy_acknowledge_out};
  rsw_status_ctrl #(.TXINH_CYC(20)) rsw_status_ctrl_i (.*);
  rsw_bc_model rsw_bc_model_i (.*);
  always #12.5 clk_sys = ~clk_sys;
  // activity pulses are one cycle long, so count them as they pass
  always @(posedge clk_sys)
    if (active_out === 1'h1)
      n_act <= n_act + 16'h0001;
  task automatic tally_and_finish;
    $display("comparisons %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wt(input int k, input logic v);
    for (int i = 0; i < 60; i++)
    begin
      #1;
      if (ws[k] === v)
        return;
      @(posedge clk_sys);
    end
    chk({15'h0, ws[k]}, {15'h0, v});
    tally_and_finish;
  endtask
  task automatic pulse(input logic [10:0] m);
    @(posedge clk_sys);
    pl <= m;
    @(posedge clk_sys);
    pl <= 11'h000;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge clk_sys);
    reg_wr <= 1'h0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge clk_sys);
    reg_rd <= 1'h0;
    #1 chk(reg_rdata, e);
  endtask
  // one command from the bus side, then the status word it produced
  task automatic msg(input logic b, input logic r, input logic [15:0] e);
    @(posedge clk_sys);
    go <= 1'h1;
    chan_b <= b;
    rep <= r;
    @(posedge clk_sys);
    go <= 1'h0;
    wt(2, 1'h0);
    chk(status_word, e);
  endtask
  task automatic t_regs;
    rd(`RSW_IDX_CFG, 16'h0000);
    rd(`RSW_IDX_PSR, 16'h0000);
    wr(`RSW_IDX_TSC, 16'hA5C3);
    rd(`RSW_IDX_TSC, 16'hA5C3);
    wr(4'h5, 16'hFFFF);
    rd(4'h5, 16'h0000);
    wr(`RSW_IDX_TSC, 16'h0000);
    rd(`RSW_IDX_STATUS, 16'hA800);
    $display("regs done");
  endtask
  task automatic t_src;
    wr(`RSW_IDX_PSR, 16'h07F5);
    msg(1'h0, 1'h0, {5'h15, 11'h7F5});
    wr(`RSW_IDX_CFG, 16'h0010);
    wr(`RSW_IDX_TSC, 16'h9000);
    pulse(11'h018);
    pulse(11'h020);
    msg(1'h1, 1'h0, {5'h15, 11'h6F2});
    bit_failure <= 1'h1;
    msg(1'h0, 1'h0, {5'h15, 11'h2E5});
    bit_failure <= 1'h0;
    subsystem_fail_in <= 1'h1;
    ta_from_register <= 1'h1;
    status_source_select <= 1'h1;
    wr(`RSW_IDX_CFG, 16'h0000);
    wr(`RSW_IDX_TSC, 16'h8C00);
    msg(1'h0, 1'h0, {5'h0A, 11'h3E5});
    subsystem_fail_in <= 1'h0;
    ta_from_register <= 1'h0;
    status_source_select <= 1'h0;
    wr(`RSW_IDX_TSC, 16'h0000);
    $display("source done");
  endtask
  task automatic t_forced_busy_in_n;
    wr(`RSW_IDX_PSR, 16'h0000);
    forced_busy_in_n <= 1'h0;
    wt(0, 1'h1);
    chk({14'h0, irq_disable, dma_inhibit}, 16'h0003);
    msg(1'h0, 1'h0, {5'h15, 11'h008});
    wr(`RSW_IDX_PSR, 16'h6000);
    msg(1'h0, 1'h0, {5'h15, 11'h000});
    wr(`RSW_IDX_PSR, 16'h2000);
    msg(1'h0, 1'h0, {5'h15, 11'h009});
    forced_busy_in_n <= 1'h1;
    wt(0, 1'h0);
    wr(`RSW_IDX_PSR, 16'h0800);
    wt(0, 1'h1);
    wr(`RSW_IDX_PSR, 16'h4100);
    msg(1'h0, 1'h0, {5'h15, 11'h101});
    wr(`RSW_IDX_PSR, 16'h1000);
    msg(1'h0, 1'h0, {5'h15, 11'h100});
    wr(`RSW_IDX_PSR, 16'h0001);
    pulse(11'h040);
    msg(1'h0, 1'h0, {5'h15, 11'h000});
    pulse(11'h080);
    msg(1'h0, 1'h0, {5'h15, 11'h001});
    wr(`RSW_IDX_TSC, 16'h0200);
    wt(0, 1'h1);
    wr(`RSW_IDX_TSC, 16'h0000);
    wt(0, 1'h0);
    $display("forced busy done");
  endtask
  task automatic t_stop;
    wr(`RSW_IDX_CFG, 16'h1000);
    pulse(11'h002);
    wt(0, 1'h1);
    rd(`RSW_IDX_MODE, 16'h000C);
    pulse(11'h004);
    wt(0, 1'h0);
    mode_bc <= 1'h1;
    pulse(11'h001);
    wt(1, 1'h1);
    repeat (8) @(posedge clk_sys);
    #1 chk({15'h0, bc_halt}, 16'h0001);
    pulse(11'h004);
    wt(1, 1'h0);
    mode_bc <= 1'h0;
    wr(`RSW_IDX_CFG, 16'h0000);
    $display("stop done");
  endtask
  task automatic t_active;
    logic [15:0] base;
    base = n_act;
    // terminal flag still programmed from the forced busy test
    for (int c = 0; c < 3; c++)
    begin
      wr(`RSW_IDX_CFG, {4'h0, (c == 2) ? 2'h3 : c[1:0], 10'h000});
      msg(1'h0, 1'h0, {5'h15, 11'h001});
      msg(1'h1, 1'h0, {5'h15, 11'h001});
    end
    // a mid-run reset must re-enable both monitors and clear the flag
    @(posedge clk_sys);
    rst <= 1'h1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'h0;
    rd(`RSW_IDX_CFG, 16'h0000);
    msg(1'h0, 1'h0, {5'h15, 11'h000});
    chk(n_act - base, 16'h0004);
    $display("activity done");
  endtask
  task automatic t_timer;
    int n;
    n = 0;
    pulse(11'h100);
    @(posedge clk_sys);
    #1;
    while (tx_inhibit_timer_chan_a === 1'h1 && n < 40)
    begin
      n++;
      @(posedge clk_sys);
      #1;
    end
    chk(n[15:0], 16'h0014);
    pulse(11'h200);
    pulse(11'h400);
    #1 chk({15'h0, tx_inhibit_timer_chan_b}, 16'h0001);
    repeat (2) @(posedge clk_sys);
    #1 chk({15'h0, tx_inhibit_timer_chan_b}, 16'h0000);
    $display("timer done");
  endtask
  task automatic t_imm;
    wr(`RSW_IDX_PSR, 16'h8010);
    msg(1'h0, 1'h0, {5'h15, 11'h010});
    rd(`RSW_IDX_PSR, 16'h8000);
    msg(1'h0, 1'h1, {5'h15, 11'h010});
    msg(1'h0, 1'h0, {5'h15, 11'h000});
    $display("immediate clear done");
  endtask
  initial
  begin
    repeat (5) @(posedge clk_sys);
    rst <= 1'h0;
    t_regs;
    t_src;
    t_forced_busy_in_n;
    t_stop;
    t_active;
    t_timer;
    t_imm;
    tally_and_finish;
  end
endmodule
bind rsw_status_ctrl rsw_status_ctrl_asserts rsw_status_ctrl_asserts_i (.*);
`default_nettype wire
